// file: hdl/cphs_top.sv
/*
  Codec port holding status: receive/transmit holding registers, their
  status flags, the receive interrupt enable and the interrupt pending logic,
  reached over Avalon-MM with waitrequest.
  Assumes the codec-side logic pulses rxLoad with rxWord and txSent when the
  held byte has left; all inputs synchronous to mclk.
*/
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps
module cphs_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic [31:0]      avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic        rxLoad,
  input  wire logic [7:0]  rxWord,
  input  wire logic        txSent,
  output logic [7:0]       txByte,
  output logic             txByteValid,
  output logic             irq
);
  typedef enum logic [1:0] {S_IDLE, S_ACK} cphs_bus_e;

  cphs_bus_e   busQ;
  cphs_bus_e   busD;
  logic [31:0] rdataQ;
  logic [31:0] rdataD;
  logic        waitQ;
  logic        waitD;
  logic [7:0]  rxDataQ;
  logic [7:0]  rxDataD;
  logic [7:0]  txDataQ;
  logic [7:0]  txDataD;
  logic        txValidQ;
  logic        txValidD;
  logic        rxIeQ;
  logic        rxIeD;
  logic        irqQ;
  logic        irqD;
  logic        rxFull;
  logic        txEmpty;
  logic        rxPend;
  logic        txPend;
  logic        accWr;
  logic        accRd;
  logic        rdRx;
  logic        wrTx;
  logic        wrIvec;
  logic        wrCtrl;
  logic [7:0]  ctrlView;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction : hit

  // an access completes in the cycle waitrequest is low
  assign accWr  = (busQ == S_ACK) && avsWrite;
  assign accRd  = (busQ == S_ACK) && avsRead;
  assign rdRx   = accRd && hit(avsAddress, cphs_pkg::OFS_RXDATA);
  assign wrTx   = accWr && hit(avsAddress, cphs_pkg::OFS_TXDATA) && avsByteenable[0];
  assign wrIvec = accWr && hit(avsAddress, cphs_pkg::OFS_IVEC);
  assign wrCtrl = accWr && hit(avsAddress, cphs_pkg::OFS_CTRL) && avsByteenable[0];

  cphs_flag uRxFull (
    .mclk  (mclk),
    .rst_n (rst_n),
    .setEv (rxLoad),
    .clrEv (rdRx),
    .flag  (rxFull)
  );

  cphs_flag uTxEmpty (
    .mclk  (mclk),
    .rst_n (rst_n),
    .setEv (txSent),
    .clrEv (wrTx),
    .flag  (txEmpty)
  );

  // pending bits are separate from the status flags so the vector write
  // can drop the interrupt while the flags keep their state
  cphs_flag uRxPend (
    .mclk  (mclk),
    .rst_n (rst_n),
    .setEv (rxLoad),
    .clrEv (wrIvec || rdRx),
    .flag  (rxPend)
  );

  cphs_flag uTxPend (
    .mclk  (mclk),
    .rst_n (rst_n),
    .setEv (txSent),
    .clrEv (wrIvec || wrTx),
    .flag  (txPend)
  );

  always_comb begin
    ctrlView = cphs_pkg::CTRL_RST;
    ctrlView[cphs_pkg::BIT_RXFULL]  = rxFull;
    ctrlView[cphs_pkg::BIT_RX_FULL_IRQ_ENABLE]    = rxIeQ;
    ctrlView[cphs_pkg::BIT_TXEMPTY] = txEmpty;
  end

  // bus handshake: one wait cycle, then acknowledge
  always_comb begin
    busD   = busQ;
    waitD  = 1'b1;
    rdataD = rdataQ;
    case (busQ)
      S_IDLE: begin
        if (avsRead || avsWrite) begin
          busD  = S_ACK;
          waitD = 1'b0;
          rdataD = cphs_pkg::RD_UNMAPPED;
          if (avsRead) begin
            case (avsAddress)
              cphs_pkg::OFS_CTRL:   rdataD = {24'h000000, ctrlView};
              cphs_pkg::OFS_RXDATA: rdataD = {24'h000000, rxDataQ};
              cphs_pkg::OFS_TXDATA: rdataD = {24'h000000, txDataQ};
              cphs_pkg::OFS_IVEC:   rdataD = {24'h000000,
                                      rxPend ? cphs_pkg::IVEC_RX :
                                      (txPend ? cphs_pkg::IVEC_TX : cphs_pkg::IVEC_NONE)};
              default:              rdataD = cphs_pkg::RD_UNMAPPED;
            endcase
          end
        end
      end
      S_ACK: begin
        busD = S_IDLE;
      end
      default: begin
        busD = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busQ   <= S_IDLE;
      waitQ  <= 1'b1;
      rdataQ <= cphs_pkg::RD_UNMAPPED;
    end else begin
      busQ   <= busD;
      waitQ  <= waitD;
      rdataQ <= rdataD;
    end
  end

  // holding registers, enable and interrupt output
  always_comb begin
    rxDataD  = rxDataQ;
    txDataD  = txDataQ;
    rxIeD    = rxIeQ;
    txValidD = 1'b0;
    if (rxLoad) begin
      rxDataD = rxWord;
    end
    if (wrTx) begin
      txDataD  = avsWritedata[7:0];
      txValidD = 1'b1;
    end
    // only bit 6 is writable; status bits ignore writes
    if (wrCtrl) begin
      rxIeD = avsWritedata[cphs_pkg::BIT_RX_FULL_IRQ_ENABLE];
    end
    irqD = rxIeQ && rxPend;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxDataQ  <= cphs_pkg::DATA_RST;
      txDataQ  <= cphs_pkg::DATA_RST;
      txValidQ <= 1'b0;
      rxIeQ    <= 1'b0;
      irqQ     <= 1'b0;
    end else begin
      rxDataQ  <= rxDataD;
      txDataQ  <= txDataD;
      txValidQ <= txValidD;
      rxIeQ    <= rxIeD;
      irqQ     <= irqD;
    end
  end

  assign avsReaddata    = rdataQ;
  assign avsWaitrequest = waitQ;
  assign txByte         = txDataQ;
  assign txByteValid    = txValidQ;
  assign irq            = irqQ;

  // receive side: flag, pending bit and holding register
  // set-wins cases are excluded from the clear checks on purpose
  a_rxfull_set: assert property (@(posedge mclk) disable iff (!rst_n)
    rxLoad |=> rxFull)
    else $error("receive-full not set after load");

  a_rxpend_set: assert property (@(posedge mclk) disable iff (!rst_n)
    rxLoad |=> rxPend)
    else $error("receive pending not set after load");

  a_rxdata_load: assert property (@(posedge mclk) disable iff (!rst_n)
    rxLoad |=> rxDataQ == $past(rxWord))
    else $error("receive word not captured");

  a_rxdata_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !rxLoad |=> $stable(rxDataQ))
    else $error("receive register changed without load");

  a_rxfull_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdRx && !rxLoad) |=> !rxFull)
    else $error("receive-full not cleared by read");

  a_rxfull_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!rxLoad && !rdRx) |=> $stable(rxFull))
    else $error("receive-full changed without cause");

  a_ivec_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrIvec && !rdRx && !wrTx) |=> ($stable(rxFull) || rxFull) && ($stable(txEmpty) || txEmpty))
    else $error("vector write changed a status flag");

  a_rxpend_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrIvec && !rxLoad) |=> !rxPend)
    else $error("receive pending not cleared by vector write");

  a_ivec_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrIvec && !rxLoad) |=> ##1 !irq)
    else $error("irq not dropped by vector write");

  // interrupt output is registered, so it trails the pending bit by one cycle
  a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    !rxIeQ |=> !irq)
    else $error("irq raised while masked");

  a_irq_raise: assert property (@(posedge mclk) disable iff (!rst_n)
    (rxIeQ && rxLoad && !wrCtrl) |=> ##1 irq)
    else $error("enabled irq not raised");

  a_irq_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    (rxIeQ && rxPend) |=> irq)
    else $error("irq low while enabled and pending");

  a_rx_full_irq_enable_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wrCtrl |=> rxIeQ == $past(avsWritedata[cphs_pkg::BIT_RX_FULL_IRQ_ENABLE]))
    else $error("receive irq enable not written");

  a_rx_full_irq_enable_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !wrCtrl |=> $stable(rxIeQ))
    else $error("receive irq enable changed without write");

  // transmit side: flag, pending bit and holding register
  a_txempty_set: assert property (@(posedge mclk) disable iff (!rst_n)
    txSent |=> txEmpty)
    else $error("transmit-empty not set");

  a_txpend_set: assert property (@(posedge mclk) disable iff (!rst_n)
    txSent |=> txPend)
    else $error("transmit pending not set");

  a_txempty_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrTx && !txSent) |=> !txEmpty && txByteValid)
    else $error("transmit-empty not cleared");

  a_txempty_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!txSent && !wrTx) |=> $stable(txEmpty))
    else $error("transmit-empty changed without cause");

  a_txdata_load: assert property (@(posedge mclk) disable iff (!rst_n)
    wrTx |=> txByte == $past(avsWritedata[7:0]))
    else $error("transmit byte not captured");

  // one access takes two cycles, so two strobes can never abut
  a_txvalid_one: assert property (@(posedge mclk) disable iff (!rst_n)
    txByteValid |=> !txByteValid)
    else $error("transmit valid longer than one cycle");

  a_txpend_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrIvec && !txSent) |=> !txPend)
    else $error("transmit pending not cleared");

  // bus handshake
  a_read_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (accRd && !rdRx && !rxLoad) |=> $stable(rxPend))
    else $error("register read disturbed receive pending");

  a_wait_first: assert property (@(posedge mclk) disable iff (!rst_n)
    ((avsRead || avsWrite) && busQ == S_IDLE) |=> !avsWaitrequest)
    else $error("request not acknowledged after one wait cycle");

  a_ack_state: assert property (@(posedge mclk) disable iff (!rst_n)
    !avsWaitrequest |-> busQ == S_ACK)
    else $error("acknowledge outside the acknowledge state");

  a_ack_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (!avsWaitrequest) |=> avsWaitrequest)
    else $error("ack longer than one cycle");
endmodule : cphs_top

// file: hdl/cphs_pkg.sv
/*
  Package for the codec port holding status block: register offsets,
  field positions, reset values and interrupt bit layout.
  Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
*/
package cphs_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  // register byte offsets
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_RXDATA    = 4'h4;
  localparam logic [3:0]  OFS_TXDATA    = 4'h8;
  localparam logic [3:0]  OFS_IVEC      = 4'hC;
  // control/status field positions
  localparam int          BIT_RXFULL    = 7;
  localparam int          BIT_RX_FULL_IRQ_ENABLE      = 6;
  localparam int          BIT_TXEMPTY   = 5;
  // reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;
  // interrupt vector values reported for receive pending, transmit pending, or neither
  localparam logic [7:0]  IVEC_RX       = 8'h01;
  localparam logic [7:0]  IVEC_TX       = 8'h02;
  localparam logic [7:0]  IVEC_NONE     = 8'h00;
endpackage : cphs_pkg

// file: hdl/cphs_flag.sv
/*
  Sticky hardware flag with set-over-clear priority.
  Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module cphs_flag (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic setEv,
  input  wire logic clrEv,
  output logic      flag
);
  logic flagQ;
  logic flagD;

  always_comb begin
    flagD = flagQ;
    if (clrEv) begin
      flagD = 1'b0;
    end
    // set wins so an event in the clearing cycle is kept
    if (setEv) begin
      flagD = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flagQ <= 1'b0;
    end else begin
      flagQ <= flagD;
    end
  end

  assign flag = flagQ;
endmodule : cphs_flag

// file: verification/cphs_codec_model.sv
/*
  Codec-side model: delivers receive words on request, reports the held
  transmit byte as sent after a programmable delay.
  Assumes the mclk domain only; requests from the bench.
*/
`timescale 1ns/100ps
module cphs_codec_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rxGo,
  input  wire logic [7:0] rxVal,
  input  wire logic [3:0] txDelay,
  input  wire logic       txByteValid,
  output logic            rxLoad,
  output logic [7:0]      rxWord,
  output logic            txSent
);
  logic [4:0] cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxLoad <= 1'b0;
      rxWord <= 8'h00;
      txSent <= 1'b0;
      cnt    <= 5'h00;
    end else begin
      rxLoad <= rxGo;
      // word only meaningful with the strobe, toggles otherwise
      rxWord <= rxGo ? rxVal : ~rxWord;
      txSent <= (cnt == 5'h01);
      if (txByteValid) cnt <= {1'b0, txDelay} + 5'h01;
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
    end
  end
endmodule : cphs_codec_model

// file: verification/test_codec_port_holding_status.sv
/*
  Self-checking bench for cphs_top: Avalon-MM master tasks and one task
  per scenario. Assumes the codec model drives the codec-side inputs.
*/
`timescale 1ns/100ps
module test_codec_port_holding_status;
  logic        mclk, rst_n, avsRead, avsWrite, rxGo, rxLoad, txSent;
  logic        avsWaitrequest, txByteValid, irq;
  logic [3:0]  avsAddress, txDelay;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [7:0]  rxVal, rxWord, txByte;
  int          failures, comparisons;
  cphs_top DUT (.mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hF),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .rxLoad(rxLoad),
    .rxWord(rxWord), .txSent(txSent), .txByte(txByte), .txByteValid(txByteValid), .irq(irq));
  cphs_codec_model codec (.mclk(mclk), .rst_n(rst_n), .rxGo(rxGo), .rxVal(rxVal),
    .txDelay(txDelay), .txByteValid(txByteValid), .rxLoad(rxLoad), .rxWord(rxWord),
    .txSent(txSent));
  task automatic complete_run;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low, then releases
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avsAddress   <= a;
    avsWritedata <= wd;
    avsWrite     <= wr;
    avsRead      <= !wr;
    @(posedge mclk iff avsWaitrequest === 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  task automatic send(input logic [7:0] w);
    rxVal <= w;
    rxGo  <= 1'b1;
    @(posedge mclk);
    rxGo <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : send
  task automatic t_reset;
    rdchk("ctrl", 4'h0, 32'h0000_0000);
    rdchk("unmapped", 4'h2, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_reset
  task automatic t_rx;
    send(8'hA5);
    rdchk("ctrl full", 4'h0, 32'h0000_0080);
    bus(1'b1, 4'h0, 32'h0000_00A0);
    rdchk("ctrl ro", 4'h0, 32'h0000_0080);
    rdchk("rxdata", 4'h4, 32'h0000_00A5);
    rdchk("ctrl cleared", 4'h0, 32'h0000_0000);
  endtask : t_rx
  task automatic t_irq;
    bus(1'b1, 4'h0, 32'h0000_0040);
    chk("irq empty", 32'h0, {31'h0, irq});
    send(8'h3C);
    chk("irq full", 32'h1, {31'h0, irq});
    rdchk("ivec rx", 4'hC, 32'h0000_0001);
    bus(1'b1, 4'hC, 32'h0);
    @(posedge mclk);
    chk("irq acked", 32'h0, {31'h0, irq});
    rdchk("ctrl kept", 4'h0, 32'h0000_00C0);
    bus(1'b1, 4'h0, 32'h0);
    send(8'h77);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 4'h0, 32'h0000_0040);
    @(posedge mclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rdchk("rxdata 2", 4'h4, 32'h0000_0077);
    @(posedge mclk);
    chk("irq read", 32'h0, {31'h0, irq});
    rdchk("ctrl rx", 4'h0, 32'h0000_0040);
  endtask : t_irq
  task automatic t_tx;
    txDelay <= 4'h3;
    bus(1'b1, 4'h8, 32'h0000_005A);
    chk("txByte", 32'h5A, {24'h0, txByte});
    repeat (6) @(posedge mclk);
    rdchk("ctrl sent", 4'h0, 32'h0000_0060);
    rdchk("ivec tx", 4'hC, 32'h0000_0002);
    bus(1'b1, 4'hC, 32'h0);
    rdchk("ivec clear", 4'hC, 32'h0000_0000);
    rdchk("ctrl ivec", 4'h0, 32'h0000_0060);
    txDelay <= 4'hF;
    bus(1'b1, 4'h8, 32'h0000_0011);
    rdchk("ctrl written", 4'h0, 32'h0000_0040);
    repeat (16) @(posedge mclk);
    rdchk("ctrl sent 2", 4'h0, 32'h0000_0060);
  endtask : t_tx
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    complete_run();
  end
  initial begin
    {rst_n, avsRead, avsWrite, rxGo} = 4'h0;
    avsAddress   = 4'h0;
    avsWritedata = 32'h0;
    rxVal        = 8'h00;
    txDelay      = 4'h0;
    failures     = 0;
    comparisons  = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_rx();
    t_irq();
    t_tx();
    complete_run();
  end
endmodule : test_codec_port_holding_status
